// ### ssup_bench.sv
// Bench for ssup_top with short reset timeouts of 8..64 cycles.
// Assumes ssup_conv_model stands behind the enables.
`timescale 1ns/10ps
`include "ssup_regs.vh"
module ssup_bench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [31:0] wb_dat_i = 32'h0;
    reg mr_n = 1'b1;
    reg pwr_pull = 1'b1;
    reg fs_pull = 1'b0;
    reg trim = 1'b1;
    reg mon = 1'b0;
    reg strap = 1'b1;
    reg [3:0] sel = 4'hf;
    reg [3:0] slow = 4'h6;
    reg [2:0] flt = 3'h0;
    reg [3:0] ov = 4'h0;
    reg [3:0] uv = 4'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, rst_oe, pwr_oe, fs_oe, aux_oe, good_oe, abit, refint;
    wire [3:0] en_oe;
    wire [3:0] cgood;
    // Open-drain pins with pull-ups
    wire pwr_pin = !(pwr_pull | pwr_oe);
    wire fs_pin = !(fs_pull | fs_oe);
    reg [3:0] hist [$];
    reg [3:0] en_q = 4'h0;
    reg [3:0] m;
    reg [31:0] rd;
    integer error_cnt = 0;
    integer checks_done = 0;
    integer n;
    integer i;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (en_oe !== en_q) hist.push_back(en_oe);
        en_q = en_oe;
    end
    ssup_top #(.RTO0_CYC(22'd8), .RTO1_CYC(22'd16), .RTO2_CYC(22'd32),
        .RTO3_CYC(22'd64)) ssup_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .manual_reset_n_i(mr_n),
        .sys_reset_oe_o(rst_oe), .power_on_request_i(pwr_pin),
        .power_on_request_oe_o(pwr_oe), .force_shutdown_n_i(fs_pin),
        .force_shutdown_oe_o(fs_oe), .supply_ov_i(ov), .supply_uv_i(uv),
        .mon_fault_i(mon), .analog_input_one_fault_i(flt[0]),
        .analog_input_two_fault_i(flt[1]), .temp_fault_i(flt[2]),
        .output_trimming_ready_i(trim), .channel_good_i(cgood),
        .aux_fault_oe_o(aux_oe), .all_good_oe_o(good_oe),
        .converter_enable_oe_o(en_oe), .address_select_bit_i(strap),
        .bus_addr_bit2_o(abit), .ref_drive_int_o(refint));
    ssup_conv_model ssup_conv_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .enable_pin_i(~en_oe), .pol_i(4'h5), .slow_i(slow),
        .channel_good_o(cgood));
    task summarize;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk_i);
        end
    endtask
    // Bounded wait on the enables (w=0) or on the reset pin (w=1)
    task wait_for(input integer w, input [3:0] exp);
        begin
            n = 0;
            while ((w ? {3'h0, rst_oe} : en_oe) !== exp && n < 2000) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n == 2000) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: wait timed out", $time);
                summarize;
            end
        end
    endtask
    task wb(input we, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n == 20) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: no bus answer", $time);
                summarize;
            end
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
        end
    endtask
    // Order 3,2,1,0 and polarity 0101 set through CTRL
    task power(input up);
        begin
            hist.delete();
            pwr_pull <= !up;
            wait_for(0, up ? 4'ha : 4'h5);
            tick(2);
            check(hist.size(), 4);
            m = up ? 4'h0 : 4'hf;
            for (i = 0; i < 4; i = i + 1) begin
                m = up ? m | (4'h8 >> i) : m & ~(4'h1 << i);
                check(hist[i], m ^ 4'h5);
            end
        end
    endtask
    initial begin
        tick(8);
        rst_i <= 1'b0;
        tick(2);
        check(rst_oe, 1'b1);
        check(en_oe, 4'hf);
        check(good_oe, 1'b1);
        check(abit, 1'b1);
        sel <= 4'h0;
        wb(1'b1, `SSUP_CTRL_ADR, 32'h0);
        sel <= 4'hf;
        wb(1'b0, `SSUP_CTRL_ADR, 32'h0);
        check(rd, {15'h0, `SSUP_CTRL_RESET});
        wb(1'b0, `SSUP_STAT_ADR, 32'h0);
        check(rd, 32'h6200);
        wb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `SSUP_CTRL_ADR, 32'h1b50);
        flt[0] <= 1'b1;
        tick(4);
        check(refint, 1'b0);
        check(aux_oe, 1'b0);
        check(en_oe, 4'h5);
        flt[0] <= 1'b0;
        $display("reset and registers done");
        power(1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            wb(1'b1, `SSUP_CTRL_ADR, 32'h1b54 + i);
            mr_n <= 1'b0;
            tick(3);
            check(rst_oe, 1'b1);
            mr_n <= 1'b1;
            wait_for(1, 4'h0);
            check(n >= (8 << i) && n <= (8 << i) + 5, 1);
        end
        check(good_oe, 1'b0);
        for (i = 0; i < 3; i = i + 1) begin
            flt[i] <= 1'b1;
            tick(3);
            check(aux_oe, 1'b1);
            flt[i] <= 1'b0;
            tick(3);
            check(aux_oe, 1'b0);
        end
        ov <= 4'h4;
        tick(3);
        check({good_oe, rst_oe}, 2'b11);
        ov <= 4'h0;
        mon <= 1'b1;
        tick(3);
        check({good_oe, rst_oe}, 2'b11);
        mon <= 1'b0;
        trim <= 1'b0;
        tick(3);
        check({good_oe, rst_oe}, 2'b11);
        trim <= 1'b1;
        $display("monitoring done");
        power(1'b0);
        slow <= 4'h9;
        power(1'b1);
        fs_pull <= 1'b1;
        tick(3);
        check(en_oe, 4'h5);
        check(pwr_pin, 1'b0);
        fs_pull <= 1'b0;
        wait_for(0, 4'ha);
        wait_for(1, 4'h0);
        $display("force shutdown done");
        wb(1'b1, `SSUP_CTRL_ADR, 32'h11b5c);
        tick(1);
        trim <= 1'b0;
        uv <= 4'h1;
        tick(4);
        check({good_oe, rst_oe, fs_oe}, 3'b000);
        fs_pull <= 1'b1;
        tick(3);
        check(en_oe, 4'ha);
        fs_pull <= 1'b0;
        $display("margining done");
        strap <= 1'b0;
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(2);
        check({abit, rst_oe, en_oe}, 6'h1f);
        $display("second reset done");
        summarize;
    end
endmodule // ssup_bench

// ### ssup_chan_drv.v
// Open-drain converter enable drivers with per-channel polarity.
// Assumes an external pull-up on each pin.
`timescale 1ns/10ps
module ssup_chan_drv #(
    parameter N = 4
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Logical enables and polarity (1 = active high)
    input wire [N-1:0] on_i,
    input wire [N-1:0] pol_i,
    // Pull-low enables
    output wire [N-1:0] oe_o
);

genvar i;

generate
    for (i = 0; i < N; i = i + 1) begin : g_ch
        reg oe_bit_reg;
        always @(posedge clk_i) begin
            if (rst_i) begin
                // Pulled low until polarity is applied
                oe_bit_reg <= 1'b1;
            end else begin
                oe_bit_reg <= on_i[i] ^ pol_i[i]; // [R11] [R16]
            end
        end
        assign oe_o[i] = oe_bit_reg;
    end
endgenerate

endmodule // ssup_chan_drv

// ### ssup_chk_asserts.sv
// Checker for the supervisor pins, bound into ssup_top.
// Assumes the CTRL layout of ssup_regs.vh and one clock domain.
`timescale 1ns/10ps
`include "ssup_regs.vh"
module ssup_chk #(
    parameter [21:0] RTO0_CYC = 22'd6400
) (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // Pins and monitor flags
    input wire manual_reset_n_i,
    input wire sys_reset_oe_o,
    input wire force_shutdown_n_i,
    input wire power_on_request_oe_o,
    input wire analog_input_one_fault_i,
    input wire analog_input_two_fault_i,
    input wire temp_fault_i,
    input wire output_trimming_ready_i,
    input wire aux_fault_oe_o,
    input wire [3:0] converter_enable_oe_o,
    input wire address_select_bit_i,
    input wire bus_addr_bit2_o,
    input wire ref_drive_int_o
);
    // Shadow of CTRL; the margin bit only relaxes checks
    reg [3:0] pol_m;
    reg mrg_m;
    reg ref_m;
    reg aux_q;
    reg [21:0] mr_cnt;
    always @(posedge clk_i) begin
        aux_q <= analog_input_one_fault_i | analog_input_two_fault_i
            | temp_fault_i;
        if (rst_i) begin
            pol_m <= 4'hf;
            mrg_m <= 1'b0;
            ref_m <= 1'b1;
            mr_cnt <= 22'h0;
        end else begin
            if (!manual_reset_n_i) begin
                mr_cnt <= 22'h0;
            end else if (mr_cnt != RTO0_CYC) begin
                mr_cnt <= mr_cnt + 22'h1;
            end
            if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                && wb_sel_i[0] && wb_adr_i == `SSUP_CTRL_ADR) begin
                pol_m <= wb_dat_i[7:4];
                mrg_m <= wb_dat_i[3];
                ref_m <= wb_dat_i[2];
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_mr_hold;
        (!manual_reset_n_i && !mrg_m) [*3] |-> sys_reset_oe_o;
    endproperty
    a_mr_hold: assert property (p_mr_hold)
        else $error("reset released during manual reset");
    property p_release;
        $fell(sys_reset_oe_o) |-> mrg_m || mr_cnt + 22'h1 >= RTO0_CYC;
    endproperty
    a_release: assert property (p_release)
        else $error("reset released before the timeout");
    property p_trim;
        !output_trimming_ready_i && !mrg_m |-> ##[1:2] sys_reset_oe_o;
    endproperty
    a_trim: assert property (p_trim)
        else $error("reset not held while trimming not ready");
    property p_fs_off;
        !force_shutdown_n_i && !mrg_m |-> ##[1:2]
            converter_enable_oe_o == pol_m;
    endproperty
    a_fs_off: assert property (p_fs_off)
        else $error("enables still on under force shutdown");
    property p_fs_req;
        $fell(force_shutdown_n_i) && !mrg_m ##1 !force_shutdown_n_i
            |=> power_on_request_oe_o;
    endproperty
    a_fs_req: assert property (p_fs_req)
        else $error("request line not pulled on force shutdown");
    property p_aux;
        aux_fault_oe_o |-> aux_q || $past(aux_q);
    endproperty
    a_aux: assert property (p_aux)
        else $error("aux fault without a fault source");
    property p_strap;
        $past(rst_i) |=> bus_addr_bit2_o == $past(address_select_bit_i);
    endproperty
    a_strap: assert property (p_strap)
        else $error("address bit differs from strap");
    property p_ref;
        !$past(rst_i) |-> ref_drive_int_o == $past(ref_m);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference select differs from control");
    c_release: cover property ($fell(sys_reset_oe_o));
    c_fs: cover property (!force_shutdown_n_i ##2 power_on_request_oe_o);
    c_aux: cover property ($rose(aux_fault_oe_o));
endmodule // ssup_chk

bind ssup_top ssup_chk #(.RTO0_CYC(RTO0_CYC)) ssup_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .manual_reset_n_i(manual_reset_n_i), .sys_reset_oe_o(sys_reset_oe_o),
    .force_shutdown_n_i(force_shutdown_n_i),
    .power_on_request_oe_o(power_on_request_oe_o),
    .analog_input_one_fault_i(analog_input_one_fault_i),
    .analog_input_two_fault_i(analog_input_two_fault_i),
    .temp_fault_i(temp_fault_i),
    .output_trimming_ready_i(output_trimming_ready_i),
    .aux_fault_oe_o(aux_fault_oe_o),
    .converter_enable_oe_o(converter_enable_oe_o),
    .address_select_bit_i(address_select_bit_i),
    .bus_addr_bit2_o(bus_addr_bit2_o), .ref_drive_int_o(ref_drive_int_o)
);

// ### ssup_conv_model.sv
// Four converters: good flag follows the enable pin after a delay.
// Assumes pin levels already resolved with the pull-ups.
`timescale 1ns/10ps
module ssup_conv_model (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Enable pins, polarity and per-channel slowness
    input wire [3:0] enable_pin_i,
    input wire [3:0] pol_i,
    input wire [3:0] slow_i,
    // Output above threshold
    output reg [3:0] channel_good_o
);
    reg [3:0] cnt_reg [0:3];
    integer k;
    always @(posedge clk_i) begin
        for (k = 0; k < 4; k = k + 1) begin
            if (rst_i) begin
                channel_good_o[k] <= 1'b0;
                cnt_reg[k] <= 4'h1;
            end else if ((enable_pin_i[k] == pol_i[k])
                == channel_good_o[k]) begin
                cnt_reg[k] <= slow_i[k] ? 4'h9 : 4'h1;
            end else if (cnt_reg[k] != 4'h0) begin
                cnt_reg[k] <= cnt_reg[k] - 4'h1;
            end else begin
                channel_good_o[k] <= ~channel_good_o[k];
            end
        end
    end
endmodule // ssup_conv_model

// ### ssup_regs.vh
// Register offsets, field positions, reset values and timing figures
// of the supply supervisor pin logic. Definitions only.
`ifndef SSUP_REGS_VH
`define SSUP_REGS_VH

// ****************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************
`define SSUP_CTRL_ADR 8'h00
`define SSUP_STAT_ADR 8'h04
`define SSUP_MASK_ADR 8'h08

// ****************************************************
// Control fields
// ****************************************************
`define SSUP_CTRL_RTO_LSB 0
`define SSUP_CTRL_REFINT_BIT 2
`define SSUP_CTRL_MARGIN_BIT 3
`define SSUP_CTRL_POL_LSB 4
`define SSUP_CTRL_ORDER_LSB 8
`define SSUP_CTRL_FSEN_BIT 16
`define SSUP_CTRL_RESET 17'h0e4f4

// ****************************************************
// Fault mask fields
// ****************************************************
`define SSUP_MASK_SUP_LSB 0
`define SSUP_MASK_MON_BIT 4
`define SSUP_MASK_ANALOG_INPUT_ONE_BIT 5
`define SSUP_MASK_ANALOG_INPUT_TWO_BIT 6
`define SSUP_MASK_TEMP_BIT 7
`define SSUP_MASK_RESET 8'hff

// ****************************************************
// Timing: clock rate and reset timeout choices
// ****************************************************
`define SSUP_CLK_MHZ 22'd10
`define SSUP_RTO0_US 22'd640
`define SSUP_RTO1_US 22'd25000
`define SSUP_RTO2_US 22'd100000
`define SSUP_RTO3_US 22'd200000

`endif

// ### ssup_rst_timer.v
// Reset timeout timer: holds the reset request while any trigger is
// active and for the selected timeout after all triggers clear.
// Assumes triggers are synchronous to clk_i.
`timescale 1ns/10ps
module ssup_rst_timer #(
    parameter [21:0] CYC0 = 22'd6400,
    parameter [21:0] CYC1 = 22'd250000,
    parameter [21:0] CYC2 = 22'd1000000,
    parameter [21:0] CYC3 = 22'd2000000
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire trig_i,
    input wire [1:0] sel_i,
    // Result
    output wire hold_o
);

reg [21:0] cnt_reg;
reg hold_reg;
reg [21:0] target;

always @* begin
    case (sel_i)
        2'd0: target = CYC0;
        2'd1: target = CYC1;
        2'd2: target = CYC2;
        default: target = CYC3;
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        cnt_reg <= 22'h000000;
        hold_reg <= 1'b1;
    end else if (trig_i) begin
        cnt_reg <= 22'h000000;
        hold_reg <= 1'b1;
    end else if (hold_reg) begin
        // Any new trigger restarts the full timeout
        if (cnt_reg >= target - 22'd1) begin
            hold_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 22'd1;
        end
    end
end

assign hold_o = hold_reg;

endmodule // ssup_rst_timer

// ### ssup_top.v
// Supervisory pin logic of a four-channel supply controller:
// manual and system reset, power-on request, force shutdown, status
// outputs, converter enables, address strap and reference select.
// Assumes all pins synchronous to clk_i, pull-ups on open-drain pins,
// and a classic Wishbone master for the registers.
`timescale 1ns/10ps
`include "ssup_regs.vh"

// Notes on behaviour
// (R1) Manual reset low drives the system reset active.
// (R2) Reset releases a timeout after the last trigger clears.
// (R3) Timeout selectable: 0.64 ms, 25 ms, 100 ms or 200 ms.
// (R4) Reset held on programmed faults, manual reset, or trimming not ready.
// (R5) Power-on request rise starts power-up; fall starts power-down.
// (R6) No fault monitoring while sequencing up or down.
// (R7) Force shutdown turns every converter enable off at once.
// (R8) Force shutdown asserted also pulls the power-on request low.
// (R9) Auxiliary fault low on analog input or temperature faults.
// (R10) All-good high only with all inputs in limits and trimming begun.
// (R11) Four open-drain enables with configurable active level.
// (R12) Address strap gives bit 2 of the serial bus address.
// (R13) Configuration selects internal reference drive or external one.
// (R14) Margining forces all-good on, reset off, ignores off triggers.
// (R15) Power-down only from monitoring, enables off in reverse order.
// (R16) Open-drain outputs are pull-low enables; released reads high.
module ssup_top #(
    parameter [21:0] RTO0_CYC = `SSUP_RTO0_US * `SSUP_CLK_MHZ,
    parameter [21:0] RTO1_CYC = `SSUP_RTO1_US * `SSUP_CLK_MHZ,
    parameter [21:0] RTO2_CYC = `SSUP_RTO2_US * `SSUP_CLK_MHZ,
    parameter [21:0] RTO3_CYC = `SSUP_RTO3_US * `SSUP_CLK_MHZ
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Reset pins
    input wire manual_reset_n_i,
    output wire sys_reset_oe_o,
    // Power-on request and force shutdown pins
    input wire power_on_request_i,
    output wire power_on_request_oe_o,
    input wire force_shutdown_n_i,
    output wire force_shutdown_oe_o,
    // Monitor results from the conversion side
    input wire [3:0] supply_ov_i,
    input wire [3:0] supply_uv_i,
    input wire mon_fault_i,
    input wire analog_input_one_fault_i,
    input wire analog_input_two_fault_i,
    input wire temp_fault_i,
    input wire output_trimming_ready_i,
    input wire [3:0] channel_good_i,
    // Status pins
    output wire aux_fault_oe_o,
    output wire all_good_oe_o,
    // Converter enables
    output wire [3:0] converter_enable_oe_o,
    // Strap and reference
    input wire address_select_bit_i,
    output wire bus_addr_bit2_o,
    output wire ref_drive_int_o
);

// ****************************************************
// States
// ****************************************************
localparam [2:0] ST_OFF = 3'd0;
localparam [2:0] ST_UP = 3'd1;
localparam [2:0] ST_MON = 3'd2;
localparam [2:0] ST_MRG = 3'd3;
localparam [2:0] ST_DN = 3'd4;

// ****************************************************
// Registers and wires
// ****************************************************
reg [16:0] ctrl_reg;
reg [7:0] mask_reg;
reg ack_reg;
reg [31:0] dat_reg;
reg [2:0] state_reg;
reg [2:0] state_next;
reg [1:0] slot_reg;
reg [1:0] slot_next;
reg [3:0] en_reg;
reg [3:0] en_next;
reg pwr_prev_reg;
reg strap_done_reg;
reg addr_bit_reg;
reg sys_reset_oe_reg;
reg pwr_oe_reg;
reg fs_oe_reg;
reg aux_oe_reg;
reg good_oe_reg;
reg ref_reg;
reg [31:0] rd_data;

wire [1:0] rto_sel = ctrl_reg[`SSUP_CTRL_RTO_LSB +: 2];
wire margin_req = ctrl_reg[`SSUP_CTRL_MARGIN_BIT];
wire [3:0] pol = ctrl_reg[`SSUP_CTRL_POL_LSB +: 4];
wire [7:0] order = ctrl_reg[`SSUP_CTRL_ORDER_LSB +: 8];
wire fs_en = ctrl_reg[`SSUP_CTRL_FSEN_BIT];
wire [1:0] cur_ch = order[{slot_reg, 1'b0} +: 2];
wire monitoring = (state_reg == ST_MON) || (state_reg == ST_MRG); // [R6]
wire margining = (state_reg == ST_MRG);
wire pwr_rise = power_on_request_i && !pwr_prev_reg; // [R5]
wire pwr_fall = !power_on_request_i && pwr_prev_reg; // [R5]
wire fs_trig = !force_shutdown_n_i && !margining; // [R7] [R14]
wire sup_fault = monitoring &&
    ((|((supply_ov_i | supply_uv_i) & mask_reg[3:0])) ||
     (mon_fault_i && mask_reg[`SSUP_MASK_MON_BIT])); // [R6]
wire aux_fault = monitoring &&
    ((analog_input_one_fault_i && mask_reg[`SSUP_MASK_ANALOG_INPUT_ONE_BIT]) ||
     (analog_input_two_fault_i && mask_reg[`SSUP_MASK_ANALOG_INPUT_TWO_BIT]) ||
     (temp_fault_i && mask_reg[`SSUP_MASK_TEMP_BIT])); // [R9]
wire any_fault = sup_fault || aux_fault;
// Sequencing counts as not ready, so reset stays active throughout
wire rst_trig = !manual_reset_n_i || any_fault ||
    !output_trimming_ready_i || !monitoring; // [R1] [R4]
wire rst_hold;
wire wb_req = wb_cyc_i && wb_stb_i;

// ****************************************************
// Wishbone slave
// ****************************************************
always @* begin
    case (wb_adr_i)
        `SSUP_CTRL_ADR: rd_data = {15'h0000, ctrl_reg};
        `SSUP_STAT_ADR: rd_data = {17'h00000, addr_bit_reg,
            force_shutdown_n_i, power_on_request_i, !good_oe_reg,
            aux_oe_reg, sys_reset_oe_reg, en_reg, slot_reg, state_reg};
        `SSUP_MASK_ADR: rd_data = {24'h000000, mask_reg};
        default: rd_data = 32'h00000000;
    endcase
end

// Write lands at the edge where the master sees ack
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_reg <= 1'b0;
        dat_reg <= 32'h00000000;
        ctrl_reg <= `SSUP_CTRL_RESET;
        mask_reg <= `SSUP_MASK_RESET;
    end else begin
        ack_reg <= wb_req && !ack_reg;
        if (wb_req && !ack_reg) begin
            dat_reg <= rd_data;
        end
        if (wb_req && ack_reg && wb_we_i) begin
            if (wb_adr_i == `SSUP_CTRL_ADR) begin
                if (wb_sel_i[0]) ctrl_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctrl_reg[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) ctrl_reg[16] <= wb_dat_i[16];
            end
            if (wb_adr_i == `SSUP_MASK_ADR && wb_sel_i[0]) begin
                mask_reg <= wb_dat_i[7:0];
            end
        end
    end
end

assign wb_ack_o = ack_reg;
assign wb_dat_o = dat_reg;

// ****************************************************
// Sequencer
// ****************************************************
always @* begin
    state_next = state_reg;
    slot_next = slot_reg;
    en_next = en_reg;
    if (fs_trig) begin
        state_next = ST_OFF; // [R7]
        slot_next = 2'd0;
        en_next = 4'h0; // [R7]
    end else begin
        case (state_reg)
            ST_OFF: begin
                if (pwr_rise) begin
                    state_next = ST_UP; // [R5]
                    slot_next = 2'd0;
                end
            end
            ST_UP: begin
                // Next slot waits for this channel to come good
                en_next[cur_ch] = 1'b1;
                if (en_reg[cur_ch] && channel_good_i[cur_ch]) begin
                    if (slot_reg == 2'd3) begin
                        state_next = ST_MON;
                    end else begin
                        slot_next = slot_reg + 2'd1;
                    end
                end
            end
            ST_MON: begin
                if (pwr_fall) begin
                    state_next = ST_DN; // [R15]
                    slot_next = 2'd3; // [R15]
                end else if (margin_req) begin
                    state_next = ST_MRG;
                end
            end
            ST_MRG: begin
                // Power-off request is ignored while margining
                if (!margin_req) begin
                    state_next = ST_MON; // [R14]
                end
            end
            ST_DN: begin
                en_next[cur_ch] = 1'b0; // [R15]
                if (!en_reg[cur_ch] && !channel_good_i[cur_ch]) begin
                    if (slot_reg == 2'd0) begin
                        state_next = ST_OFF;
                    end else begin
                        slot_next = slot_reg - 2'd1; // [R15]
                    end
                end
            end
            default: begin
                state_next = ST_OFF;
                slot_next = 2'd0;
                en_next = 4'h0;
            end
        endcase
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        state_reg <= ST_OFF;
        slot_reg <= 2'd0;
        en_reg <= 4'h0;
        pwr_prev_reg <= 1'b1;
    end else begin
        state_reg <= state_next;
        slot_reg <= slot_next;
        en_reg <= en_next;
        pwr_prev_reg <= power_on_request_i;
    end
end

ssup_chan_drv #(
    .N(4)
) u_chan_drv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .on_i(en_next),
    .pol_i(pol),
    .oe_o(converter_enable_oe_o)
);

// ****************************************************
// System reset timing
// ****************************************************
ssup_rst_timer #(
    .CYC0(RTO0_CYC),
    .CYC1(RTO1_CYC),
    .CYC2(RTO2_CYC),
    .CYC3(RTO3_CYC)
) u_rst_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_i(rst_trig), // [R2]
    .sel_i(rto_sel), // [R3]
    .hold_o(rst_hold)
);

// ****************************************************
// Pin drivers and strap capture
// ****************************************************
always @(posedge clk_i) begin
    if (rst_i) begin
        sys_reset_oe_reg <= 1'b1;
        pwr_oe_reg <= 1'b0;
        fs_oe_reg <= 1'b0;
        aux_oe_reg <= 1'b0;
        good_oe_reg <= 1'b1;
        ref_reg <= 1'b0;
        strap_done_reg <= 1'b0;
        addr_bit_reg <= 1'b0;
    end else begin
        // Margining overrides the threshold-driven reset
        sys_reset_oe_reg <= !margining && rst_hold; // [R1] [R2] [R14] [R16]
        pwr_oe_reg <= !force_shutdown_n_i; // [R8]
        // Device itself forces shutdown on supply faults if enabled
        fs_oe_reg <= fs_en && sup_fault && !margining; // [R14]
        aux_oe_reg <= aux_fault; // [R9] [R16]
        good_oe_reg <= !(margining || (state_reg == ST_MON &&
            !any_fault && output_trimming_ready_i)); // [R10] [R14]
        ref_reg <= ctrl_reg[`SSUP_CTRL_REFINT_BIT]; // [R13]
        // Strap sampled once, on the first edge after reset
        if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            addr_bit_reg <= address_select_bit_i; // [R12]
        end
    end
end

assign sys_reset_oe_o = sys_reset_oe_reg;
assign power_on_request_oe_o = pwr_oe_reg;
assign force_shutdown_oe_o = fs_oe_reg;
assign aux_fault_oe_o = aux_oe_reg;
assign all_good_oe_o = good_oe_reg;
assign bus_addr_bit2_o = addr_bit_reg;
assign ref_drive_int_o = ref_reg;

endmodule // ssup_top
